// >>> shared/spcp_consts.vh
// Purpose: constants of the servo position command path
// Assumes: 32-bit apb data, byte addresses, 10 MHz clock
// Notes:   reset values are the power-on defaults of the parameters
`ifndef SPCP_CONSTS_VH
`define SPCP_CONSTS_VH
// ==========================================================
// register byte offsets
`define SPCP_OFS_GEAR_NUM    8'h00
`define SPCP_OFS_GEAR_DEN    8'h04
`define SPCP_OFS_PFACTOR     8'h08
`define SPCP_OFS_FILT_CFG    8'h0c
`define SPCP_OFS_EXP_TC      8'h10
`define SPCP_OFS_LIN_TC      8'h14
`define SPCP_OFS_HOLD_SPEED  8'h18
`define SPCP_OFS_LOOP_GAIN   8'h1c
`define SPCP_OFS_CTRL        8'h20
`define SPCP_OFS_DONE_RANGE  8'h24
`define SPCP_OFS_STATUS      8'h28
`define SPCP_OFS_DEVIATION   8'h2c
// ==========================================================
// field positions of the control register
`define SPCP_CTRL_PF_EN      0
`define SPCP_CTRL_ALLOC      1
`define SPCP_CTRL_PIN_LO     4
`define SPCP_CTRL_PIN_HI     6
`define SPCP_CTRL_MODE_LO    8
`define SPCP_CTRL_MODE_HI    11
// ==========================================================
// reset values, hold mode code and write limits
`define SPCP_RST_GEAR_NUM    16'h0004
`define SPCP_RST_GEAR_DEN    16'h0001
`define SPCP_RST_PFACTOR     8'h01
`define SPCP_RST_TC          13'h0000
`define SPCP_RST_HOLD_SPEED  14'h000a
`define SPCP_RST_LOOP_GAIN   16'h0028
`define SPCP_RST_DONE_RANGE  16'h0007
`define SPCP_RST_PIN         3'h0
`define SPCP_RST_MODE        4'h0
`define SPCP_MODE_SPD_LOCK   4'ha
`define SPCP_TC_MAX          13'h1900
`define SPCP_SPEED_MAX       14'h2710
// ==========================================================
// timing: filter step of 0.01 ms at a 100 ns clock
`define SPCP_CLK_NS          100
`define SPCP_TICK_NS         10000
`define SPCP_TICK_CYC        (`SPCP_TICK_NS / `SPCP_CLK_NS)
`endif

// >>> logic/spcp_top.v
// Purpose: command pulse path of a servo position loop: pulse factor,
//          position command filter, electronic gear and position hold
// Assumes: all inputs synchronous to CLK_I; one command pulse per cycle
// Notes:   registers on apb, zero wait states, unmapped gives pslverr
`timescale 1ns/1ps
`include "spcp_consts.vh"
module spcp_top #(
   parameter DEF_PIN = 3'h0
) (
   input  wire        CLK_I,
   input  wire        RST_I,
   input  wire        PSEL_I,
   input  wire        PENABLE_I,
   input  wire        PWRITE_I,
   input  wire [7:0]  PADDR_I,
   input  wire [31:0] PWDATA_I,
   output reg  [31:0] PRDATA_O,
   output wire        PREADY_O,
   output reg         PSLVERR_O,
   input  wire        POWER_RESTART_I,
   input  wire        CMD_PULSE_I,
   input  wire        CMD_DIR_I,
   input  wire        FACTOR_SW_I,
   input  wire [7:0]  INPUT_PINS_I,
   input  wire [13:0] MOTOR_SPEED_I,
   input  wire [13:0] SPEED_CMD_I,
   output reg         MOTOR_PULSE_O,
   output reg         MOTOR_DIR_O,
   output reg         POS_HOLD_O,
   output reg  [15:0] LOOP_GAIN_O,
   output reg         POS_DONE_O
);
   // =======================================================
   // register file
   reg  [15:0] gear_num_ff, gear_den_ff;
   reg  [7:0]  pfactor_ff;
   reg         filt_sel_ff;
   reg  [12:0] exp_tc_ff, lin_tc_ff;
   reg  [13:0] hold_speed_ff;
   reg  [15:0] loop_gain_ff;
   reg         pf_en_ff, alloc_ff;
   reg  [2:0]  pin_sel_ff;
   reg  [3:0]  mode_ff;
   reg  [15:0] done_range_ff;
   reg  [15:0] act_num_ff, act_den_ff;
   reg         loaded_ff;
   wire        wr_en, rd_en, hit;
   wire [31:0] dev_w;
   // clamp a written time constant into its settable range
   function [12:0] clamp_tc;
      input [31:0] v;
      begin
         clamp_tc = (v > {19'h0, `SPCP_TC_MAX}) ? `SPCP_TC_MAX : v[12:0];
      end
   endfunction
   assign PREADY_O = 1'b1;
   assign wr_en    = PSEL_I & PENABLE_I & PWRITE_I & hit;
   assign rd_en    = PSEL_I & ~PWRITE_I;
   assign hit      = (PADDR_I[1:0] == 2'h0) &&
                     (PADDR_I <= `SPCP_OFS_CTRL ||
                      PADDR_I == `SPCP_OFS_DONE_RANGE);
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         gear_num_ff   <= `SPCP_RST_GEAR_NUM;
         gear_den_ff   <= `SPCP_RST_GEAR_DEN;
         pfactor_ff    <= `SPCP_RST_PFACTOR;
         filt_sel_ff   <= 1'b0;
         exp_tc_ff     <= `SPCP_RST_TC;
         lin_tc_ff     <= `SPCP_RST_TC;
         hold_speed_ff <= `SPCP_RST_HOLD_SPEED;
         loop_gain_ff  <= `SPCP_RST_LOOP_GAIN;
         pf_en_ff      <= 1'b0;
         alloc_ff      <= 1'b0;
         pin_sel_ff    <= `SPCP_RST_PIN;
         mode_ff       <= `SPCP_RST_MODE;
         done_range_ff <= `SPCP_RST_DONE_RANGE;
      end else if (wr_en) begin
         case (PADDR_I)
            `SPCP_OFS_GEAR_NUM: gear_num_ff <= PWDATA_I[15:0];
            `SPCP_OFS_GEAR_DEN: gear_den_ff <= PWDATA_I[15:0];
            `SPCP_OFS_PFACTOR:  pfactor_ff  <= PWDATA_I[7:0];
            `SPCP_OFS_FILT_CFG: filt_sel_ff <= PWDATA_I[0];
            `SPCP_OFS_EXP_TC:   exp_tc_ff   <= clamp_tc(PWDATA_I);
            `SPCP_OFS_LIN_TC:   lin_tc_ff   <= clamp_tc(PWDATA_I);
            `SPCP_OFS_HOLD_SPEED: begin
               if (PWDATA_I > {18'h0, `SPCP_SPEED_MAX})
                  hold_speed_ff <= `SPCP_SPEED_MAX;
               else
                  hold_speed_ff <= PWDATA_I[13:0];
            end
            `SPCP_OFS_LOOP_GAIN: loop_gain_ff <= PWDATA_I[15:0];
            `SPCP_OFS_CTRL: begin
               pf_en_ff   <= PWDATA_I[`SPCP_CTRL_PF_EN];
               alloc_ff   <= PWDATA_I[`SPCP_CTRL_ALLOC];
               pin_sel_ff <= PWDATA_I[`SPCP_CTRL_PIN_HI:`SPCP_CTRL_PIN_LO];
               mode_ff    <= PWDATA_I[`SPCP_CTRL_MODE_HI:`SPCP_CTRL_MODE_LO];
            end
            `SPCP_OFS_DONE_RANGE: done_range_ff <= PWDATA_I[15:0];
            default: done_range_ff <= done_range_ff;
         endcase
      end
   end
   // the running ratio is copied only once after reset and at a power
   // restart, so later writes sit staged until the next restart
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         act_num_ff <= `SPCP_RST_GEAR_NUM;
         act_den_ff <= `SPCP_RST_GEAR_DEN;
         loaded_ff  <= 1'b0;
      end else begin
         loaded_ff <= 1'b1;
         if (!loaded_ff || POWER_RESTART_I) begin
            act_num_ff <= gear_num_ff;
            act_den_ff <= (gear_den_ff == 16'h0) ? 16'h1 : gear_den_ff;
         end
      end
   end

   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         PRDATA_O  <= 32'h0;
         PSLVERR_O <= 1'b0;
      end else if (PSEL_I & ~PENABLE_I) begin
         PSLVERR_O <= ~hit & ~(rd_en & (PADDR_I == `SPCP_OFS_STATUS ||
                                        PADDR_I == `SPCP_OFS_DEVIATION));
         case (PADDR_I)
            `SPCP_OFS_GEAR_NUM:   PRDATA_O <= {16'h0, gear_num_ff};
            `SPCP_OFS_GEAR_DEN:   PRDATA_O <= {16'h0, gear_den_ff};
            `SPCP_OFS_PFACTOR:    PRDATA_O <= {24'h0, pfactor_ff};
            `SPCP_OFS_FILT_CFG:   PRDATA_O <= {31'h0, filt_sel_ff};
            `SPCP_OFS_EXP_TC:     PRDATA_O <= {19'h0, exp_tc_ff};
            `SPCP_OFS_LIN_TC:     PRDATA_O <= {19'h0, lin_tc_ff};
            `SPCP_OFS_HOLD_SPEED: PRDATA_O <= {18'h0, hold_speed_ff};
            `SPCP_OFS_LOOP_GAIN:  PRDATA_O <= {16'h0, loop_gain_ff};
            `SPCP_OFS_CTRL:       PRDATA_O <= {20'h0, mode_ff, 1'b0,
                                     pin_sel_ff, 2'h0, alloc_ff, pf_en_ff};
            `SPCP_OFS_DONE_RANGE: PRDATA_O <= {16'h0, done_range_ff};
            `SPCP_OFS_STATUS:     PRDATA_O <= {29'h0,
                                     (act_num_ff != gear_num_ff) ||
                                     (act_den_ff != gear_den_ff),
                                     POS_DONE_O, POS_HOLD_O};
            `SPCP_OFS_DEVIATION:  PRDATA_O <= dev_w;
            default:              PRDATA_O <= 32'h0;
         endcase
      end
   end

   // =======================================================
   // position command filter, in command units
   reg  [6:0]         tick_cnt_ff, nxt_tick_cnt;
   reg  signed [7:0]  rate_cnt_ff, rate_ff, step_ff;
   reg  signed [7:0]  nxt_rate_cnt, nxt_rate, nxt_step;
   reg  signed [31:0] pend_ff, resid_ff, vel_ff;
   reg  signed [31:0] nxt_pend, nxt_resid, nxt_vel;
   reg                f_pulse, f_dir;
   reg  signed [31:0] tgt, dv;
   wire [12:0]        tc;
   wire signed [31:0] tc_s;
   wire               tick;
   assign tc   = filt_sel_ff ? lin_tc_ff : exp_tc_ff;
   assign tc_s = $signed({19'h0, tc});
   assign tick = (tick_cnt_ff == `SPCP_TICK_CYC - 1);
   assign dev_w = pend_ff;
   always @* begin
      nxt_tick_cnt = tick ? 7'h0 : tick_cnt_ff + 7'h1;
      nxt_rate_cnt = rate_cnt_ff;
      nxt_rate     = rate_ff;
      nxt_step     = step_ff;
      nxt_pend     = pend_ff;
      nxt_resid    = resid_ff;
      nxt_vel      = vel_ff;
      f_pulse      = 1'b0;
      f_dir        = 1'b0;
      tgt          = 32'sh0;
      dv           = 32'sh0;
      if (CMD_PULSE_I) begin
         nxt_pend     = CMD_DIR_I ? pend_ff - 1 : pend_ff + 1;
         nxt_rate_cnt = CMD_DIR_I ? rate_cnt_ff - 8'sh1
                                  : rate_cnt_ff + 8'sh1;
      end
      if (tc == 13'h0) begin
         // unfiltered: the pulse goes straight through
         f_pulse   = CMD_PULSE_I;
         f_dir     = CMD_DIR_I;
         nxt_pend  = pend_ff;
         nxt_resid = 32'sh0;
         nxt_vel   = 32'sh0;
         nxt_rate_cnt = 8'sh0;
      end else begin
         if (tick) begin
            nxt_rate     = nxt_rate_cnt;
            nxt_rate_cnt = 8'sh0;
            if (!filt_sel_ff) begin
               // first order: rate out is pending count over tc
               nxt_resid = resid_ff + pend_ff;
            end else begin
               // linear: velocity walks to the new rate in tc ticks
               tgt = nxt_rate * tc_s;
               if (nxt_rate != 8'sh0)
                  nxt_step = (nxt_rate < 0) ? -nxt_rate : nxt_rate;
               dv = tgt - vel_ff;
               if (dv > step_ff)
                  nxt_vel = vel_ff + step_ff;
               else if (dv < -step_ff)
                  nxt_vel = vel_ff - step_ff;
               else
                  nxt_vel = tgt;
               nxt_resid = resid_ff + nxt_vel;
               // flush rounding leftovers once the ramp is idle
               if (nxt_vel == 32'sh0 && resid_ff < tc_s &&
                   resid_ff > -tc_s)
                  nxt_resid = (pend_ff > 0) ? tc_s :
                              (pend_ff < 0) ? -tc_s : 32'sh0;
            end
         end else if (resid_ff >= tc_s && pend_ff > 0) begin
            f_pulse   = 1'b1;
            nxt_resid = resid_ff - tc_s;
            nxt_pend  = nxt_pend - 1;
         end else if (resid_ff <= -tc_s && pend_ff < 0) begin
            f_pulse   = 1'b1;
            f_dir     = 1'b1;
            nxt_resid = resid_ff + tc_s;
            nxt_pend  = nxt_pend + 1;
         end
      end
   end

   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         tick_cnt_ff <= 7'h0;
         rate_cnt_ff <= 8'sh0;
         rate_ff     <= 8'sh0;
         step_ff     <= 8'sh1;
         pend_ff     <= 32'sh0;
         resid_ff    <= 32'sh0;
         vel_ff      <= 32'sh0;
      end else begin
         tick_cnt_ff <= nxt_tick_cnt;
         rate_cnt_ff <= nxt_rate_cnt;
         rate_ff     <= nxt_rate;
         step_ff     <= nxt_step;
         pend_ff     <= nxt_pend;
         resid_ff    <= nxt_resid;
         vel_ff      <= nxt_vel;
      end
   end

   // =======================================================
   // electronic gear; one motor count is a quadrature edge, so
   // ratio one needs four times the encoder lines per turn
   reg  signed [31:0] acc_ff, nxt_acc;
   reg                nxt_mpulse, nxt_mdir;
   wire [23:0]        inc;
   wire signed [31:0] den_s;
   assign inc = act_num_ff * ((pf_en_ff & FACTOR_SW_I) ?
                              pfactor_ff : 8'h1);
   assign den_s = $signed({16'h0, act_den_ff});
   always @* begin
      nxt_acc    = acc_ff;
      nxt_mpulse = 1'b0;
      nxt_mdir   = MOTOR_DIR_O;
      if (f_pulse)
         nxt_acc = f_dir ? acc_ff - $signed({8'h0, inc})
                         : acc_ff + $signed({8'h0, inc});
      // the remainder stays in the accumulator for later pulses
      if (nxt_acc >= den_s) begin
         nxt_acc    = nxt_acc - den_s;
         nxt_mpulse = 1'b1;
         nxt_mdir   = 1'b0;
      end else if (nxt_acc <= -den_s) begin
         nxt_acc    = nxt_acc + den_s;
         nxt_mpulse = 1'b1;
         nxt_mdir   = 1'b1;
      end
   end

   // =======================================================
   // position hold
   wire        hold_in, hold_now;
   wire [2:0]  pin_idx;
   wire [31:0] dev_abs;
   // the default pin stays in force until user allocation is chosen
   assign pin_idx  = alloc_ff ? pin_sel_ff : DEF_PIN;
   assign hold_in  = INPUT_PINS_I[pin_idx];
   assign hold_now = (mode_ff == `SPCP_MODE_SPD_LOCK) && hold_in &&
                     (MOTOR_SPEED_I <= hold_speed_ff) &&
                     (SPEED_CMD_I < hold_speed_ff);
   assign dev_abs  = pend_ff[31] ? -pend_ff : pend_ff;
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         acc_ff        <= 32'sh0;
         MOTOR_PULSE_O <= 1'b0;
         MOTOR_DIR_O   <= 1'b0;
         POS_HOLD_O    <= 1'b0;
         LOOP_GAIN_O   <= 16'h0;
         POS_DONE_O    <= 1'b1;
      end else begin
         acc_ff        <= nxt_acc;
         MOTOR_PULSE_O <= nxt_mpulse;
         MOTOR_DIR_O   <= nxt_mdir;
         POS_HOLD_O    <= hold_now;
         LOOP_GAIN_O   <= hold_now ? loop_gain_ff : 16'h0;
         POS_DONE_O    <= (dev_abs <= {16'h0, done_range_ff});
      end
   end
endmodule

// >>> bench/spcp_monitor.sv
// Purpose: port checker for spcp_top
// Assumes: bound to every spcp_top instance
// Notes:   configuration is hidden, so only config-free relations
`timescale 1ns/1ps
`include "spcp_consts.vh"
module spcp_monitor (
   input wire logic        CLK_I,
   input wire logic        RST_I,
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic        PWRITE_I,
   input wire logic [7:0]  PADDR_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic        PREADY_O,
   input wire logic        PSLVERR_O,
   input wire logic [7:0]  INPUT_PINS_I,
   input wire logic [13:0] SPEED_CMD_I,
   input wire logic        POS_HOLD_O,
   input wire logic [15:0] LOOP_GAIN_O
);
   // ==========================================
   // apb phases
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   sequence setup_s; PSEL_I && !PENABLE_I; endsequence
   sequence access_s; PSEL_I && PENABLE_I; endsequence
   chk_ready_tied: assert property (PREADY_O)
      else $error("pready low");
   chk_unmapped_err: assert property (setup_s ##0
      (PADDR_I > 8'h2c || PADDR_I[1:0] != 2'h0) |=> PSLVERR_O)
      else $error("unmapped access without error");
   chk_ro_write: assert property (setup_s ##0 (PWRITE_I &&
      (PADDR_I == 8'h28 || PADDR_I == 8'h2c)) |=> PSLVERR_O)
      else $error("read-only write without error");
   chk_mapped_ok: assert property (setup_s ##0 (!PWRITE_I &&
      PADDR_I <= 8'h2c && PADDR_I[1:0] == 2'h0) |=> !PSLVERR_O)
      else $error("mapped read flagged");
   chk_rdata_hold: assert property (access_s ##1 !PSEL_I
      |-> $stable(PRDATA_O))
      else $error("read data moved after access");
   // ==========================================
   // position hold
   chk_gain_idle: assert property (
      !POS_HOLD_O |-> LOOP_GAIN_O == 16'h0000)
      else $error("loop gain outside hold");
   chk_cmd_high: assert property (
      SPEED_CMD_I >= `SPCP_SPEED_MAX |=> !POS_HOLD_O)
      else $error("hold with high speed command");
   chk_pin_low: assert property (
      INPUT_PINS_I == 8'h00 |=> !POS_HOLD_O)
      else $error("hold with all inputs low");
   chk_hold_cause: assert property ($rose(POS_HOLD_O) |->
      $past(SPEED_CMD_I) < `SPCP_SPEED_MAX && $past(INPUT_PINS_I) != 8'h00)
      else $error("hold entered without cause");
endmodule
bind spcp_top spcp_monitor spcp_monitor_i (.CLK_I(CLK_I), .RST_I(RST_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
   .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
   .PSLVERR_O(PSLVERR_O), .INPUT_PINS_I(INPUT_PINS_I),
   .SPEED_CMD_I(SPEED_CMD_I), .POS_HOLD_O(POS_HOLD_O),
   .LOOP_GAIN_O(LOOP_GAIN_O));

// >>> bench/spcp_host_model.sv
// Purpose: host controller sending bursts of command pulses
// Assumes: start is a one-cycle request
// Notes:   gap sets cycles between pulses, 0 is back to back
`timescale 1ns/1ps
module spcp_host_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       start_i,
   input  wire logic [7:0] count_i,
   input  wire logic       dir_i,
   input  wire logic [3:0] gap_i,
   output logic            pulse_o,
   output logic            dir_o,
   output logic            busy_o
);
   logic [7:0] left_ff;
   logic [3:0] wait_ff;
   logic       fire;
   assign fire = !start_i && left_ff != 8'h00 && wait_ff == 4'h0;
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         {pulse_o, dir_o, busy_o, left_ff, wait_ff} <= '0;
      end else begin
         pulse_o <= fire;
         // direction means nothing between pulses, so it toggles there
         dir_o <= fire ? dir_i : ~dir_o;
         if (start_i) begin
            left_ff <= count_i;
            wait_ff <= 4'h0;
            busy_o <= 1'b1;
         end else if (fire) begin
            left_ff <= left_ff - 8'h01;
            wait_ff <= gap_i;
         end else if (left_ff != 8'h00) begin
            wait_ff <= wait_ff - 4'h1;
         end else busy_o <= 1'b0;
      end
   end
endmodule

// >>> bench/spcp_top_test.sv
// Purpose: self-checking bench of spcp_top
// Assumes: zero wait state apb, default hold pin 0
// Notes:   motor pulses are counted per burst
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
   err_count++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module spcp_top_test;
   logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, prst = 0;
   logic [7:0]  paddr = 0, pins = 0, ofs[8], bcnt = 0;
   logic [31:0] pwdata = 0, prdata, rdata, rv[8];
   logic        pready, pslverr, rerr, fsw = 0, start = 0, bdir = 0;
   logic [13:0] mspd = 0, scmd = 0;
   logic [3:0]  bgap = 0;
   logic        cpul, cdir, busy, mpul, mdir_o, hold, done, mdir;
   logic [15:0] gain;
   int          err_count = 0, n_compared = 0, cyc = 0;
   logic [31:0] mcount = 0;
   // ==========================================
   // clock, pulse counting, timeout
   initial forever #50 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (mpul === 1'b1) begin mcount++; mdir = mdir_o; end
      if (cyc == 60000) begin err_count++; results(); end
   end
   spcp_host_model spcp_host_model_i (.clk_i(clk), .rst_i(rst),
      .start_i(start), .count_i(bcnt), .dir_i(bdir), .gap_i(bgap),
      .pulse_o(cpul), .dir_o(cdir), .busy_o(busy));
   spcp_top #(.DEF_PIN(3'h0)) spcp_top_i (.CLK_I(clk), .RST_I(rst),
      .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .POWER_RESTART_I(prst), .CMD_PULSE_I(cpul),
      .CMD_DIR_I(cdir), .FACTOR_SW_I(fsw), .INPUT_PINS_I(pins),
      .MOTOR_SPEED_I(mspd), .SPEED_CMD_I(scmd), .MOTOR_PULSE_O(mpul),
      .MOTOR_DIR_O(mdir_o), .POS_HOLD_O(hold), .LOOP_GAIN_O(gain),
      .POS_DONE_O(done));
   // ==========================================
   // access tasks
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0; pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK("read data", e, rdata)
   endtask
   task automatic burst(input logic [7:0] n, input logic d,
                        input logic [3:0] g);
      mcount = 0;
      bcnt <= n; bdir <= d; bgap <= g; start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (2) @(posedge clk);
      while (busy) @(posedge clk);
      repeat (20) @(posedge clk);
   endtask
   task automatic restart();
      prst <= 1'b1;
      @(posedge clk);
      prst <= 1'b0;
      @(posedge clk);
   endtask
   task automatic hchk(input logic [7:0] p, input logic [13:0] m,
                       input logic [13:0] c, input logic e);
      pins <= p; mspd <= m; scmd <= c;
      repeat (3) @(posedge clk);
      `CHK("hold", e, hold)
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ==========================================
   // tests
   initial begin
      ofs = '{8'h00, 8'h04, 8'h08, 8'h1c, 8'h18, 8'h24, 8'h20, 8'h0c};
      rv = '{32'h4, 32'h1, 32'h1, 32'h28, 32'ha, 32'h7, 32'h0, 32'h0};
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 8; i++) rd(ofs[i], rv[i]);
      apb(1'b0, 8'h30, 32'h0);
      `CHK("unmapped err", 1'b1, rerr)
      apb(1'b1, 8'h28, 32'h1);
      `CHK("ro write err", 1'b1, rerr)
      $display("test registers ended");
      burst(3, 1'b0, 0);
      `CHK("fwd count", 32'd12, mcount)
      `CHK("fwd dir", 1'b0, mdir)
      burst(3, 1'b1, 3);
      `CHK("rev count", 32'd12, mcount)
      `CHK("rev dir", 1'b1, mdir)
      apb(1'b1, 8'h00, 32'h1);
      rd(8'h28, 32'h6);
      burst(2, 1'b0, 0);
      `CHK("staged gear", 32'd8, mcount)
      restart();
      rd(8'h28, 32'h2);
      burst(2, 1'b0, 0);
      `CHK("unity gear", 32'd2, mcount)
      apb(1'b1, 8'h04, 32'h3);
      restart();
      burst(6, 1'b0, 1);
      `CHK("third a", 32'd2, mcount)
      burst(1, 1'b0, 0);
      `CHK("third b", 32'd0, mcount)
      burst(2, 1'b0, 0);
      `CHK("third c", 32'd1, mcount)
      apb(1'b1, 8'h04, 32'h1);
      restart();
      apb(1'b1, 8'h08, 32'h3);
      apb(1'b1, 8'h20, 32'h1);
      fsw <= 1'b1;
      burst(2, 1'b0, 2);
      `CHK("factor on", 32'd6, mcount)
      fsw <= 1'b0;
      burst(2, 1'b0, 0);
      `CHK("factor off", 32'd2, mcount)
      $display("test gear ended");
      apb(1'b1, 8'h24, 32'h2);
      apb(1'b1, 8'h10, 32'h5);
      burst(4, 1'b0, 1);
      `CHK("exp delayed", 32'd0, mcount)
      rd(8'h2c, 32'h4);
      `CHK("done low", 1'b0, done)
      repeat (3000) @(posedge clk);
      `CHK("exp total", 32'd4, mcount)
      `CHK("done high", 1'b1, done)
      apb(1'b1, 8'h0c, 32'h1);
      apb(1'b1, 8'h14, 32'h5);
      burst(4, 1'b0, 1);
      repeat (3000) @(posedge clk);
      `CHK("lin total", 32'd4, mcount)
      apb(1'b1, 8'h14, 32'h0);
      burst(2, 1'b0, 0);
      `CHK("no filter", 32'd2, mcount)
      apb(1'b1, 8'h10, 32'hffff);
      rd(8'h10, 32'h1900);
      apb(1'b1, 8'h18, 32'hffff);
      rd(8'h18, 32'h2710);
      $display("test filter ended");
      apb(1'b1, 8'h18, 32'd100);
      apb(1'b1, 8'h1c, 32'h1234);
      apb(1'b1, 8'h20, 32'h0a00);
      hchk(8'h01, 14'd5, 14'd50, 1'b1);
      `CHK("hold gain", 16'h1234, gain)
      hchk(8'h01, 14'd5, 14'd100, 1'b0);
      hchk(8'h01, 14'd100, 14'd50, 1'b1);
      hchk(8'h01, 14'd101, 14'd50, 1'b0);
      hchk(8'h00, 14'd5, 14'd50, 1'b0);
      apb(1'b1, 8'h20, 32'h0a32);
      hchk(8'h01, 14'd5, 14'd50, 1'b0);
      hchk(8'h08, 14'd5, 14'd50, 1'b1);
      apb(1'b1, 8'h18, 32'hffff);
      hchk(8'h08, 14'd5, 14'd10000, 1'b0);
      hchk(8'h08, 14'd10000, 14'd9999, 1'b1);
      apb(1'b1, 8'h20, 32'h0);
      hchk(8'h08, 14'd5, 14'd50, 1'b0);
      $display("test hold ended");
      results();
   end
endmodule
